// file: aerms_map.svh
/*
 * Register offsets, field positions, reset values and bit layouts of the
 * uncorrectable error mask and severity bank.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef AERMS_MAP_SVH
`define AERMS_MAP_SVH

`define AERMS_ADDR_W 12
`define AERMS_DATA_W 32
`define AERMS_PTR_W 5

`define AERMS_OFF_STATUS 12'h104
`define AERMS_OFF_SUPPRESS 12'h108
`define AERMS_OFF_FATALITY 12'h10c
`define AERMS_OFF_FIRST_ERR 12'h118
`define AERMS_OFF_IRQ_MASK 12'h1f0

`define AERMS_BIT_TRAINING 0
`define AERMS_BIT_DL_PROTOCOL 4
`define AERMS_BIT_POISONED 12
`define AERMS_BIT_FC_PROTOCOL 13
`define AERMS_BIT_CPL_TIMEOUT 14
`define AERMS_BIT_CPL_ABORT 15
`define AERMS_BIT_UNEXP_CPL 16
`define AERMS_BIT_RX_OVERFLOW 17
`define AERMS_BIT_MALFORMED 18
`define AERMS_BIT_ECRC 19
`define AERMS_BIT_UNSUP_REQ 20
`define AERMS_BIT_ACS_VIOL 21

`define AERMS_DEFINED_BITS 32'h003f_f011
`define AERMS_RST_STATUS 32'h0000_0000
`define AERMS_RST_SUPPRESS 32'h0000_0000
`define AERMS_RST_FATALITY 32'h0006_2011
`define AERMS_RST_IRQ_MASK 32'h003f_f011
`define AERMS_RST_PTR 5'h00

`endif

// file: aerms_pkg.sv
/*
 * Types shared by the uncorrectable error mask and severity bank.
 * Assumes aerms_map.svh is on the include path.
 */
`include "aerms_map.svh"

package aerms_pkg;
	typedef logic [`AERMS_DATA_W-1:0] aerms_word_t;
	typedef logic [`AERMS_ADDR_W-1:0] aerms_addr_t;
	typedef logic [`AERMS_PTR_W-1:0] aerms_ptr_t;
endpackage : aerms_pkg

// file: aerms_status_bits.sv
/*
 * Sticky write-one-to-clear error status bits, one per defined error.
 * Assumes one-cycle event strobes and a one-cycle clear vector, both on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "aerms_map.svh"

module aerms_status_bits
	import aerms_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire aerms_pkg::aerms_word_t errEvent,
	input wire aerms_pkg::aerms_word_t clearBits,
	output logic [31:0] status
);
	import aerms_pkg::*;

	aerms_word_t next_status;

	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : g_bit
			localparam aerms_word_t DEF = `AERMS_DEFINED_BITS;
			if (DEF[i]) begin : g_def
				// Set wins over a same-cycle clear
				always_comb begin
					next_status[i] = errEvent[i] | (status[i] & ~clearBits[i]);
				end
			end else begin : g_rsv
				always_comb begin
					next_status[i] = 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status <= `AERMS_RST_STATUS;
		end else begin
			status <= next_status;
		end
	end
endmodule : aerms_status_bits

`default_nettype wire

// file: aerms_lowest_bit.sv
/*
 * Finds the lowest set bit of a 32-bit vector and returns its position.
 * Purely combinational; assumes nothing of its surroundings.
 */
`timescale 1ns/10ps
`default_nettype none
`include "aerms_map.svh"

module aerms_lowest_bit
	import aerms_pkg::*;
(
	input wire aerms_pkg::aerms_word_t vec,
	output aerms_pkg::aerms_ptr_t index,
	output logic found
);
	import aerms_pkg::*;

	always_comb begin
		index = `AERMS_RST_PTR;
		found = 1'b0;
		for (int k = 31; k >= 0; k--) begin
			if (vec[k]) begin
				index = aerms_ptr_t'(k);
				found = 1'b1;
			end
		end
	end
endmodule : aerms_lowest_bit

`default_nettype wire

// file: aerms_bank.sv
/*
 * Uncorrectable error mask and severity bank of one switch port, with the
 * status bits, first error pointer, header log strobe, pending error
 * messages and an interrupt.
 * Assumes one-cycle error event strobes from the port logic, a header log
 * that captures on logCapture, and a message generator that acknowledges
 * each pending message with a one-cycle accept.
 */
`timescale 1ns/10ps
`default_nettype none
`include "aerms_map.svh"

module aerms_bank
	import aerms_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire aerms_pkg::aerms_addr_t regAddr,
	input wire aerms_pkg::aerms_word_t regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output aerms_pkg::aerms_word_t regReadData,
	input wire aerms_pkg::aerms_word_t errEvent,
	output aerms_pkg::aerms_word_t errStatus,
	output aerms_pkg::aerms_word_t errSuppress,
	output aerms_pkg::aerms_word_t errFatality,
	output logic logCapture,
	output aerms_pkg::aerms_ptr_t logBit,
	output aerms_pkg::aerms_ptr_t firstErrPtr,
	output logic fatalMsgReq,
	input wire logic fatalMsgAccept,
	output logic nonFatalMsgReq,
	input wire logic nonFatalMsgAccept,
	output logic irq
);
	import aerms_pkg::*;

	localparam aerms_word_t DEFINED = `AERMS_DEFINED_BITS;

	// Register file state
	aerms_word_t suppress;
	aerms_word_t fatality;
	aerms_word_t irqMask;
	aerms_word_t next_suppress;
	aerms_word_t next_fatality;
	aerms_word_t next_irqMask;
	aerms_word_t next_regReadData;

	// Error path state
	aerms_ptr_t ptr;
	logic ptrValid;
	logic logStrobe;
	aerms_ptr_t logIndex;
	logic fatalPending;
	logic nonFatalPending;
	aerms_ptr_t next_ptr;
	logic next_ptrValid;
	logic next_logStrobe;
	aerms_ptr_t next_logIndex;
	logic next_fatalPending;
	logic next_nonFatalPending;

	// Decode and derived terms
	logic hitStatus;
	logic hitSuppress;
	logic hitFatality;
	logic hitFirstErr;
	logic hitIrqMask;
	aerms_word_t clearBits;
	aerms_word_t status;
	aerms_word_t reported;
	aerms_word_t ptrBit;
	aerms_ptr_t lowIndex;
	logic lowFound;
	logic anyFatal;
	logic anyNonFatal;
	logic ptrCleared;

	always_comb begin
		hitStatus = (regAddr == `AERMS_OFF_STATUS);
		hitSuppress = (regAddr == `AERMS_OFF_SUPPRESS);
		hitFatality = (regAddr == `AERMS_OFF_FATALITY);
		hitFirstErr = (regAddr == `AERMS_OFF_FIRST_ERR);
		hitIrqMask = (regAddr == `AERMS_OFF_IRQ_MASK);
	end

	// Write-one-to-clear of the status bits
	always_comb begin
		clearBits = '0;
		if (regWrite && hitStatus) begin
			clearBits = regWriteData & DEFINED;
		end
	end

	aerms_status_bits u_status (
		.sys_clk(sys_clk),
		.rst(rst),
		.errEvent(errEvent & DEFINED),
		.clearBits(clearBits),
		.status(status)
	);

	// Only unmasked events reach the log and the message path
	always_comb begin
		reported = errEvent & DEFINED & ~suppress;
		anyFatal = |(reported & fatality);
		anyNonFatal = |(reported & ~fatality);
	end

	aerms_lowest_bit u_lowest (
		.vec(reported),
		.index(lowIndex),
		.found(lowFound)
	);

	// Register file
	always_comb begin
		next_suppress = suppress;
		next_fatality = fatality;
		next_irqMask = irqMask;
		if (regWrite && hitSuppress) begin
			next_suppress = regWriteData & DEFINED;
		end
		if (regWrite && hitFatality) begin
			next_fatality = regWriteData & DEFINED;
		end
		if (regWrite && hitIrqMask) begin
			next_irqMask = regWriteData & DEFINED;
		end
	end

	// Read data valid in the cycle after the strobe only
	always_comb begin
		next_regReadData = '0;
		if (regRead) begin
			if (hitStatus) begin
				next_regReadData = status;
			end else if (hitSuppress) begin
				next_regReadData = suppress;
			end else if (hitFatality) begin
				next_regReadData = fatality;
			end else if (hitFirstErr) begin
				next_regReadData = {27'h0000000, ptr};
			end else if (hitIrqMask) begin
				next_regReadData = irqMask;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			suppress <= `AERMS_RST_SUPPRESS;
			fatality <= `AERMS_RST_FATALITY;
			irqMask <= `AERMS_RST_IRQ_MASK;
			regReadData <= '0;
		end else begin
			suppress <= next_suppress;
			fatality <= next_fatality;
			irqMask <= next_irqMask;
			regReadData <= next_regReadData;
		end
	end

	// First error pointer, header log strobe and pending messages
	always_comb begin
		ptrBit = aerms_word_t'(1) << ptr;
		ptrCleared = ptrValid && |(clearBits & ptrBit);
		next_ptr = ptr;
		next_ptrValid = ptrValid;
		next_logStrobe = 1'b0;
		next_logIndex = logIndex;
		if (ptrCleared) begin
			next_ptrValid = 1'b0;
		end
		// A new error in the clearing cycle still takes the pointer
		if (lowFound && (!ptrValid || ptrCleared)) begin
			next_ptr = lowIndex;
			next_ptrValid = 1'b1;
			next_logStrobe = 1'b1;
			next_logIndex = lowIndex;
		end
		next_fatalPending = anyFatal | (fatalPending & ~fatalMsgAccept);
		next_nonFatalPending = anyNonFatal | (nonFatalPending & ~nonFatalMsgAccept);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ptr <= `AERMS_RST_PTR;
			ptrValid <= 1'b0;
			logStrobe <= 1'b0;
			logIndex <= `AERMS_RST_PTR;
			fatalPending <= 1'b0;
			nonFatalPending <= 1'b0;
		end else begin
			ptr <= next_ptr;
			ptrValid <= next_ptrValid;
			logStrobe <= next_logStrobe;
			logIndex <= next_logIndex;
			fatalPending <= next_fatalPending;
			nonFatalPending <= next_nonFatalPending;
		end
	end

	always_comb begin
		errStatus = status;
		errSuppress = suppress;
		errFatality = fatality;
		logCapture = logStrobe;
		logBit = logIndex;
		firstErrPtr = ptr;
		fatalMsgReq = fatalPending;
		nonFatalMsgReq = nonFatalPending;
		irq = |(status & ~irqMask);
	end
endmodule : aerms_bank

`default_nettype wire

// file: aerms_bank_chk.sv
/* Port assertions for the mask and severity bank.
 Assumes binding to aerms_bank on one clock with a synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
`include "aerms_map.svh"
module aerms_bank_chk
	import aerms_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire aerms_pkg::aerms_addr_t regAddr,
	input wire logic regRead,
	input wire aerms_pkg::aerms_word_t regReadData,
	input wire aerms_pkg::aerms_word_t errEvent,
	input wire aerms_pkg::aerms_word_t errStatus,
	input wire aerms_pkg::aerms_word_t errSuppress,
	input wire aerms_pkg::aerms_word_t errFatality,
	input wire logic logCapture,
	input wire aerms_pkg::aerms_ptr_t logBit,
	input wire aerms_pkg::aerms_ptr_t firstErrPtr,
	input wire logic fatalMsgReq,
	input wire logic nonFatalMsgReq
);
	localparam aerms_word_t DEF = `AERMS_DEFINED_BITS;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_status; |(errEvent & DEF) |=> &(errStatus | ~($past(errEvent) & DEF)); endproperty
	property p_nolog; (errEvent & DEF & ~errSuppress) == '0 |=> !logCapture; endproperty
	property p_nomsg;
		!fatalMsgReq && !nonFatalMsgReq && (errEvent & DEF & ~errSuppress) == '0
			|=> !fatalMsgReq && !nonFatalMsgReq;
	endproperty
	property p_fatal; |(errEvent & DEF & ~errSuppress & errFatality) |=> fatalMsgReq; endproperty
	property p_nonfatal; |(errEvent & DEF & ~errSuppress & ~errFatality) |=> nonFatalMsgReq; endproperty
	property p_rdmask; regRead && regAddr == 12'h108 |=> regReadData == $past(errSuppress); endproperty
	property p_rdsev; regRead && regAddr == 12'h10c |=> regReadData == $past(errFatality); endproperty
	property p_ptr; logCapture |-> firstErrPtr == logBit && errStatus[logBit]; endproperty
	a_status: assert property (p_status) else $error("status bit not set");
	a_nolog: assert property (p_nolog) else $error("masked error logged");
	a_nomsg: assert property (p_nomsg) else $error("masked error sent");
	a_fatal: assert property (p_fatal) else $error("fatal message missing");
	a_nonfatal: assert property (p_nonfatal) else $error("non-fatal message missing");
	a_rdmask: assert property (p_rdmask) else $error("mask read wrong");
	a_rdsev: assert property (p_rdsev) else $error("severity read wrong");
	a_ptr: assert property (p_ptr) else $error("pointer wrong");
	c_log: cover property (logCapture);
	c_fatal: cover property (fatalMsgReq ##1 !fatalMsgReq);
	c_nonfatal: cover property (nonFatalMsgReq ##1 !nonFatalMsgReq);
endmodule : aerms_bank_chk
bind aerms_bank aerms_bank_chk i_chk (.*);
`default_nettype wire

// file: aerms_rc_model.sv
/* Far-end message consumer: acknowledges a pending message DELAY+1 cycles after it is raised.
 Assumes one request level per instance on sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module aerms_rc_model #(
	parameter int DELAY = 0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req,
	output logic accept = 1'b0
);
	int cnt = 0;
	always @(posedge sys_clk) begin
		if (rst || !req || accept) begin
			cnt <= 0;
			accept <= 1'b0;
		end else if (cnt == DELAY) begin
			accept <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : aerms_rc_model
`default_nettype wire

// file: aer_uncorrectable_mask_severity_tb_top.sv
/* Self-checking bench for the mask and severity bank.
 Assumes bank, checker and far-end model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "aerms_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module aer_uncorrectable_mask_severity_tb_top;
	import aerms_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
	logic fatalMsgAccept, nonFatalMsgAccept, logCapture, fatalMsgReq, nonFatalMsgReq, irq;
	aerms_addr_t regAddr = '0;
	aerms_word_t regWriteData = '0, errEvent = '0, regReadData, errStatus, errSuppress, errFatality;
	aerms_ptr_t logBit, firstErrPtr;
	int errors = 0, compares = 0;
	localparam aerms_word_t SEV = `AERMS_RST_FATALITY;
	localparam aerms_word_t DEF = `AERMS_DEFINED_BITS;
	int bits [12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
	always #4 sys_clk = ~sys_clk;
	aerms_bank i_dut (.*);
	aerms_rc_model #(.DELAY(0)) i_rcFatal (.sys_clk(sys_clk), .rst(rst), .req(fatalMsgReq),
		.accept(fatalMsgAccept));
	aerms_rc_model #(.DELAY(3)) i_rcNonFatal (.sys_clk(sys_clk), .rst(rst),
		.req(nonFatalMsgReq), .accept(nonFatalMsgAccept));
	task automatic wr(input aerms_addr_t a, input aerms_word_t d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input aerms_addr_t a, input aerms_word_t e);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1;
		`CHK(regReadData, e)
	endtask : rd
	task automatic evw(input aerms_word_t w);
		@(posedge sys_clk);
		errEvent <= w;
		@(posedge sys_clk);
		errEvent <= '0;
		#1;
	endtask : evw
	task automatic evt(input int b);
		evw(32'h1 << b);
	endtask : evt
	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#200000;
		errors++;
		report_and_stop();
	end
	initial begin
		int b;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`AERMS_OFF_SUPPRESS, '0);
		rd(`AERMS_OFF_FATALITY, SEV);
		rd(`AERMS_OFF_STATUS, '0);
		rd(`AERMS_OFF_FIRST_ERR, '0);
		rd(`AERMS_OFF_IRQ_MASK, DEF);
		rd(12'h200, '0);
		wr(`AERMS_OFF_SUPPRESS, '1);
		`CHK(errSuppress, DEF)
		rd(`AERMS_OFF_SUPPRESS, DEF);
		wr(`AERMS_OFF_FATALITY, ~SEV);
		`CHK(errFatality, ~SEV & DEF)
		rd(`AERMS_OFF_FATALITY, ~SEV & DEF);
		wr(`AERMS_OFF_FATALITY, SEV);
		foreach (bits[i]) begin
			b = bits[i];
			wr(`AERMS_OFF_SUPPRESS, 32'h1 << b);
			evt(b);
			`CHK(errStatus[b], 1'b1)
			`CHK({logCapture, fatalMsgReq, nonFatalMsgReq}, 3'b000)
			wr(`AERMS_OFF_SUPPRESS, DEF ^ (32'h1 << b));
			evt(b);
			`CHK({logCapture, logBit, firstErrPtr}, {1'b1, 5'(b), 5'(b)})
			`CHK({fatalMsgReq, nonFatalMsgReq}, {SEV[b], ~SEV[b]})
			rd(`AERMS_OFF_FIRST_ERR, 32'(b));
			wr(`AERMS_OFF_STATUS, 32'h1 << b);
			rd(`AERMS_OFF_STATUS, '0);
			repeat (4) @(posedge sys_clk);
		end
		wr(`AERMS_OFF_IRQ_MASK, '0);
		evt(4);
		`CHK(irq, 1'b1)
		wr(`AERMS_OFF_IRQ_MASK, DEF);
		`CHK(irq, 1'b0)
		wr(`AERMS_OFF_IRQ_MASK, '0);
		`CHK(irq, 1'b1)
		wr(`AERMS_OFF_STATUS, 32'h10);
		`CHK(irq, 1'b0)
		// Two events at once, then one while the pointer is held
		wr(`AERMS_OFF_SUPPRESS, '0);
		evw(32'h0004_4000);
		`CHK({logCapture, logBit, fatalMsgReq, nonFatalMsgReq}, {1'b1, 5'h0e, 2'b11})
		evt(12);
		`CHK({logCapture, firstErrPtr, errStatus[12]}, {1'b0, 5'h0e, 1'b1})
		wr(`AERMS_OFF_STATUS, 32'h1 << 14);
		rd(`AERMS_OFF_FIRST_ERR, 32'h0000_000e);
		evt(19);
		`CHK({logCapture, logBit, firstErrPtr}, {1'b1, 5'h13, 5'h13})
		// Reset in mid-run returns the mask, severity, status and first error pointer registers to their reset values
		wr(`AERMS_OFF_SUPPRESS, '1);
		wr(`AERMS_OFF_FATALITY, '0);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`AERMS_OFF_SUPPRESS, '0);
		rd(`AERMS_OFF_FATALITY, SEV);
		rd(`AERMS_OFF_STATUS, '0);
		rd(`AERMS_OFF_FIRST_ERR, '0);
		`CHK({errSuppress, errFatality, fatalMsgReq, nonFatalMsgReq}, {32'h0, SEV, 2'b00})
		report_and_stop();
	end
endmodule : aer_uncorrectable_mask_severity_tb_top
`default_nettype wire
